// >>> rtl/bko_regs.vh
`ifndef BKO_REGS_VH
`define BKO_REGS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define BKO_OFF_CTRL 12'h000
`define BKO_OFF_TRAV 12'h004
`define BKO_OFF_CPUL 12'h008
`define BKO_OFF_OPUL 12'h00c
`define BKO_OFF_TERM 12'h010
`define BKO_OFF_FTRP 12'h014
`define BKO_OFF_STAT 12'h018
`define BKO_OFF_REQ 12'h01c
// ----------------------------------------
// ctrl fields
// ----------------------------------------
`define BKO_CTRL_SYNC 0
`define BKO_CTRL_RDY_LO 1
`define BKO_CTRL_RDY_HI 2
`define BKO_CTRL_ACC_LO 3
`define BKO_CTRL_ACC_HI 4
`define BKO_CTRL_WD 5
`define BKO_CTRL_RST 32'h0000_0014
// ----------------------------------------
// timing: 20 ms tick, settings in ticks
// ----------------------------------------
`define BKO_CLK_HZ 100000000
`define BKO_TICK_MS 20
`define BKO_TICK_CYC (`BKO_CLK_HZ / 1000 * `BKO_TICK_MS)
`define BKO_TRAV_RST 16'h000a
`define BKO_PUL_RST 16'h000a
`define BKO_TERM_RST 16'h01f4
`define BKO_FTRP_RST 16'h000a
// ----------------------------------------
// positions
// ----------------------------------------
`define BKO_POS_MID 2'h0
`define BKO_POS_OPEN 2'h1
`define BKO_POS_CLOSED 2'h2
`define BKO_POS_BAD 2'h3
`endif

// >>> rtl/bko_pos_mon.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-contact position monitor
// ----------------------------------------
module bko_pos_mon (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // inputs, already synchronised
  input wire a_i,
  input wire b_i,
  input wire tick_i,
  input wire [15:0] trav_i,
  // result
  output reg [1:0] pos_o
);
`include "bko_regs.vh"
  reg [15:0] cnt;
  wire settled = (a_i ^ b_i);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
      pos_o <= `BKO_POS_MID;
    end else if (settled) begin
      cnt <= 16'h0000;
      pos_o <= a_i ? `BKO_POS_OPEN : `BKO_POS_CLOSED;
    end else if (cnt >= trav_i) begin
      // both high after traverse time: bad, neither: intermediate
      pos_o <= (a_i & b_i) ? `BKO_POS_BAD : `BKO_POS_MID;
    end else if (tick_i) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/bko_object.v
// Function
// - open-status input high means object is open.
// - close-status input high means object is closed.
// - cart-in high means withdrawable cart is in service.
// - cart-out high means withdrawable cart is pulled out.
// - ready input high means spring charged, ready to close.
// - synchrocheck input high means closing is permitted.
// - both status inputs high beyond traverse time reports bad.
// - neither status input high after traverse time reports intermediate.
// - close pulse limited to configurable length, default 0.2 s.
// - open pulse limited to configurable length, default 0.2 s.
// - pulse drops early when commanded position reached.
// - no status change within termination timeout raises error, ends control.
// - final-trip pulse of set length; zero means continuous.
// - with auto-reclose, final trip only when no reclose expected.
// - panel control gated by required access level, default configurator.
// - open and close commands are pulses on separate relay outputs.
// - synchrocheck gating, when enabled, rejects close without permission.
// - ready gating selects high, low or unused; default unused.
`timescale 1ns/1ps
`default_nettype none
`include "bko_regs.vh"
module bko_object #(
  parameter TICK_CYC = `BKO_TICK_CYC
) (
  // clock and reset
  input wire CLOCK_I,
  input wire RST_N_I,
  // axi4-lite write
  input wire [11:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  // axi4-lite read
  input wire [11:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I,
  // object contacts (pins)
  input wire OPEN_STATUS_I,
  input wire CLOSE_STATUS_I,
  input wire CART_IN_INPUT_I,
  input wire CART_OUT_INPUT_I,
  input wire READY_I,
  input wire SYNC_OK_I,
  // request sources
  input wire LOCAL_OPEN_I,
  input wire LOCAL_CLOSE_I,
  input wire REMOTE_OPEN_I,
  input wire REMOTE_CLOSE_I,
  input wire APP_OPEN_I,
  input wire APP_CLOSE_I,
  input wire [1:0] PANEL_LEVEL_I,
  input wire RECLOSE_PENDING_I,
  // relays and status
  output reg OPEN_CMD_O,
  output reg CLOSE_CMD_O,
  output reg FINAL_TRIP_O,
  output reg CTRL_ERROR_O
);
// ----------------------------------------
// pin synchronisers, three stages
// ----------------------------------------
  localparam NSYNC = 12;
  wire [NSYNC-1:0] raw = {OPEN_STATUS_I, CLOSE_STATUS_I, CART_IN_INPUT_I, CART_OUT_INPUT_I, READY_I, SYNC_OK_I,
    LOCAL_OPEN_I, LOCAL_CLOSE_I, REMOTE_OPEN_I, REMOTE_CLOSE_I, APP_OPEN_I, APP_CLOSE_I};
  reg [NSYNC-1:0] s1, s2, s3, flt;
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1 <= 12'h000;
      s2 <= 12'h000;
      s3 <= 12'h000;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : gsync
      always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I)
          flt[g] <= 1'b0;
        else if (s2[g] == s3[g])
          flt[g] <= s2[g];
      end
    end
  endgenerate
  wire st_open = flt[11];
  wire st_closed = flt[10];
  wire cart_in = flt[9];
  wire cart_out = flt[8];
  wire ready = flt[7];
  wire sync_ok = flt[6];
  wire loc_open = flt[5];
  wire loc_close = flt[4];
  wire rem_open = flt[3];
  wire rem_close = flt[2];
  wire app_open = flt[1];
  wire app_close = flt[0];
// ----------------------------------------
// registers
// ----------------------------------------
  reg [31:0] ctrl;
  reg [15:0] trav, cpul, opul, term, ftrp;
  reg panel_open, panel_close;
  reg err_flag, clr_err;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg aw_have, w_have;
  assign AWREADY_O = !aw_have && !BVALID_O;
  assign WREADY_O = !w_have && !BVALID_O;
  wire do_wr = aw_have && w_have && !BVALID_O;
  wire [31:0] wmask = {{8{WSTRB_I[3]}}, {8{WSTRB_I[2]}}, {8{WSTRB_I[1]}}, {8{WSTRB_I[0]}}};
  reg [3:0] wstrb;
  wire [31:0] wm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [31:0] m;
    begin
      merge16 = (old & ~m[15:0]) | (d[15:0] & m[15:0]);
    end
  endfunction
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      wstrb <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'h0;
      ctrl <= `BKO_CTRL_RST;
      trav <= `BKO_TRAV_RST;
      cpul <= `BKO_PUL_RST;
      opul <= `BKO_PUL_RST;
      term <= `BKO_TERM_RST;
      ftrp <= `BKO_FTRP_RST;
      panel_open <= 1'b0;
      panel_close <= 1'b0;
      clr_err <= 1'b0;
    end else begin
      panel_open <= 1'b0;
      panel_close <= 1'b0;
      clr_err <= 1'b0;
      if (AWVALID_I && AWREADY_O) begin
        aw_have <= 1'b1;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_have <= 1'b1;
        w_data <= WDATA_I & wmask;
        wstrb <= WSTRB_I;
      end
      if (BVALID_O && BREADY_I)
        BVALID_O <= 1'b0;
      if (do_wr) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= 2'h0;
        case ({aw_addr[11:2], 2'b00})
          `BKO_OFF_CTRL: ctrl <= (ctrl & ~wm) | (w_data & wm);
          `BKO_OFF_TRAV: trav <= merge16(trav, w_data, wm);
          `BKO_OFF_CPUL: cpul <= merge16(cpul, w_data, wm);
          `BKO_OFF_OPUL: opul <= merge16(opul, w_data, wm);
          `BKO_OFF_TERM: term <= merge16(term, w_data, wm);
          `BKO_OFF_FTRP: ftrp <= merge16(ftrp, w_data, wm);
          `BKO_OFF_STAT: clr_err <= w_data[4];
          `BKO_OFF_REQ: begin
            // panel request, gated by access level
            if (PANEL_LEVEL_I >= ctrl[`BKO_CTRL_ACC_HI:`BKO_CTRL_ACC_LO]) begin
              panel_open <= w_data[0];
              panel_close <= w_data[1];
            end else
              BRESP_O <= 2'h2;
          end
          default: BRESP_O <= 2'h2;
        endcase
      end
    end
  end
// ----------------------------------------
// time tick
// ----------------------------------------
  reg [31:0] tdiv;
  reg tick;
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tdiv <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (tdiv == TICK_CYC - 1);
      tdiv <= (tdiv == TICK_CYC - 1) ? 32'h0000_0000 : tdiv + 32'h0000_0001;
    end
  end
// ----------------------------------------
// position monitors
// ----------------------------------------
  wire [1:0] brk_pos, cart_pos;
  bko_pos_mon u_brk (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .a_i(st_open), .b_i(st_closed), .tick_i(tick),
    .trav_i(trav), .pos_o(brk_pos));
  bko_pos_mon u_cart (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .a_i(cart_out), .b_i(cart_in), .tick_i(tick),
    .trav_i(trav), .pos_o(cart_pos));
// ----------------------------------------
// command sequencer
// ----------------------------------------
  localparam S_IDLE = 2'h0;
  localparam S_OPEN = 2'h1;
  localparam S_CLOSE = 2'h2;
  reg [1:0] state;
  reg [15:0] pcnt, tcnt, fcnt;
  wire req_open = loc_open | rem_open | app_open | panel_open;
  wire req_close = loc_close | rem_close | app_close | panel_close;
  wire sync_pass = !ctrl[`BKO_CTRL_SYNC] || sync_ok;
  wire [1:0] rsel = ctrl[`BKO_CTRL_RDY_HI:`BKO_CTRL_RDY_LO];
  wire rdy_pass = (rsel == 2'h0) ? ready : (rsel == 2'h1) ? !ready : 1'b1;
  reg fin_act;
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= S_IDLE;
      pcnt <= 16'h0000;
      tcnt <= 16'h0000;
      OPEN_CMD_O <= 1'b0;
      CLOSE_CMD_O <= 1'b0;
      err_flag <= 1'b0;
      fin_act <= 1'b0;
    end else begin
      if (clr_err)
        err_flag <= 1'b0;
      fin_act <= 1'b0;
      case (state)
        S_IDLE: begin
          pcnt <= 16'h0000;
          tcnt <= 16'h0000;
          if (req_open) begin
            state <= S_OPEN;
            OPEN_CMD_O <= 1'b1;
          end else if (req_close && sync_pass && rdy_pass) begin
            state <= S_CLOSE;
            CLOSE_CMD_O <= 1'b1;
          end
        end
        S_OPEN, S_CLOSE: begin
          if (tick) begin
            pcnt <= pcnt + 16'h0001;
            tcnt <= tcnt + 16'h0001;
          end
          if (tick && pcnt + 16'h0001 >= (state == S_OPEN ? opul : cpul)) begin
            OPEN_CMD_O <= 1'b0;
            CLOSE_CMD_O <= 1'b0;
          end
          if (brk_pos == (state == S_OPEN ? `BKO_POS_OPEN : `BKO_POS_CLOSED)) begin
            OPEN_CMD_O <= 1'b0;
            CLOSE_CMD_O <= 1'b0;
            state <= S_IDLE;
            fin_act <= (state == S_OPEN) && !RECLOSE_PENDING_I;
          end else if (tick && tcnt + 16'h0001 >= term) begin
            OPEN_CMD_O <= 1'b0;
            CLOSE_CMD_O <= 1'b0;
            err_flag <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
// ----------------------------------------
// final trip pulse
// ----------------------------------------
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FINAL_TRIP_O <= 1'b0;
      CTRL_ERROR_O <= 1'b0;
      fcnt <= 16'h0000;
    end else begin
      CTRL_ERROR_O <= err_flag;
      if (fin_act) begin
        FINAL_TRIP_O <= 1'b1;
        fcnt <= 16'h0000;
      end else if (FINAL_TRIP_O && ftrp != 16'h0000 && tick) begin
        if (fcnt + 16'h0001 >= ftrp)
          FINAL_TRIP_O <= 1'b0;
        else
          fcnt <= fcnt + 16'h0001;
      end else if (FINAL_TRIP_O && ftrp == 16'h0000 && req_close)
        FINAL_TRIP_O <= 1'b0;
    end
  end
// ----------------------------------------
// read channel
// ----------------------------------------
  assign ARREADY_O = !RVALID_O;
  wire [31:0] stat = {24'h0, 1'b0, ready, sync_ok, err_flag, cart_pos, brk_pos};
  always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= 2'h0;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RRESP_O <= 2'h0;
      case ({ARADDR_I[11:2], 2'b00})
        `BKO_OFF_CTRL: RDATA_O <= ctrl;
        `BKO_OFF_TRAV: RDATA_O <= {16'h0, trav};
        `BKO_OFF_CPUL: RDATA_O <= {16'h0, cpul};
        `BKO_OFF_OPUL: RDATA_O <= {16'h0, opul};
        `BKO_OFF_TERM: RDATA_O <= {16'h0, term};
        `BKO_OFF_FTRP: RDATA_O <= {16'h0, ftrp};
        `BKO_OFF_STAT: RDATA_O <= stat;
        `BKO_OFF_REQ: RDATA_O <= {30'h0, CLOSE_CMD_O, OPEN_CMD_O};
        default: begin
          RDATA_O <= 32'h0000_0000;
          RRESP_O <= 2'h2;
        end
      endcase
    end else if (RVALID_O && RREADY_I)
      RVALID_O <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> dv/bko_object_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bko_object_asserts (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // bus handshakes
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic RVALID_O,
  // object side
  input wire logic OPEN_STATUS_I,
  input wire logic CLOSE_STATUS_I,
  input wire logic RECLOSE_PENDING_I,
  input wire logic OPEN_CMD_O,
  input wire logic CLOSE_CMD_O,
  input wire logic FINAL_TRIP_O,
  input wire logic CTRL_ERROR_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------
  // bus steps
  // ----------------------------------------
  sequence s_wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence s_rd_taken;
    ARVALID_I && ARREADY_O;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 BVALID_O)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_taken |=> RVALID_O)
    else $error("read response late");
  a_wr_refuse: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken while response pending");
  a_rd_refuse: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read taken while response pending");
  // ----------------------------------------
  // relay behaviour
  // ----------------------------------------
  a_cmd_exclusive: assert property (!(OPEN_CMD_O && CLOSE_CMD_O))
    else $error("open and close commands together");
  a_open_drop: assert property ((OPEN_STATUS_I && !CLOSE_STATUS_I) [*8] |-> !OPEN_CMD_O)
    else $error("open pulse held after open reached");
  a_close_drop: assert property ((CLOSE_STATUS_I && !OPEN_STATUS_I) [*8] |-> !CLOSE_CMD_O)
    else $error("close pulse held after closed reached");
  a_error_ends: assert property ($rose(CTRL_ERROR_O) |-> !OPEN_CMD_O && !CLOSE_CMD_O)
    else $error("control not ended on error");
  a_trip_opened: assert property ($rose(FINAL_TRIP_O) |-> OPEN_STATUS_I)
    else $error("final trip without open object");
  a_trip_final: assert property ($rose(FINAL_TRIP_O) |-> !RECLOSE_PENDING_I)
    else $error("final trip while reclose expected");
endmodule
`default_nettype wire

// >>> dv/bko_breaker_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// breaker contacts: 0 normal, 1 stuck, 2 both, 3 none
// ----------------------------------------
module bko_breaker_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // relay coils and behaviour
  input wire logic open_cmd_i,
  input wire logic close_cmd_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] delay_i,
  // auxiliary contacts
  output logic open_st_o,
  output logic close_st_o
);
  logic closed;
  logic [7:0] cnt;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      closed <= 1'b0;
      cnt <= 8'h00;
    end else if (mode_i != 2'h1 && ((open_cmd_i && closed) || (close_cmd_i && !closed))) begin
      cnt <= (cnt == delay_i) ? 8'h00 : cnt + 8'h01;
      if (cnt == delay_i) begin
        closed <= !closed;
      end
    end else begin
      cnt <= 8'h00;
    end
  end
  // contacts both low while travelling
  assign open_st_o = (mode_i == 2'h2) || (mode_i != 2'h3 && cnt == 8'h00 && !closed);
  assign close_st_o = (mode_i == 2'h2) || (mode_i != 2'h3 && cnt == 8'h00 && closed);
endmodule
`default_nettype wire

// >>> dv/test_breaker_object_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "bko_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_breaker_object_control;
  localparam int T = 10;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0;
  // local, remote, app: open then close
  logic [5:0] rq = 6'h00;
  logic [1:0] lvl = 2'h2, mode = 2'h0, eb;
  logic cin = 1'b1, cout = 1'b0, rdy = 1'b1, syn = 1'b1, recl = 1'b0;
  logic [7:0] dly = 8'h10;
  wire awr, wr_r, bv, arr, rv, ost, cst, ocmd, ccmd, ftrip, err;
  wire [1:0] brsp, rrsp;
  wire [31:0] rdat;
  int n_mismatch = 0, checks_done = 0, cyc = 0, lo, hi;
  logic [65:0] q_r[$], e;
  logic [1:0] q_b[$];
  int q_p[3][$];
  int len[3] = '{0, 0, 0};
  logic [2:0] hv;
  always #5 clk = ~clk;
  bko_object #(.TICK_CYC(T)) u_bko_object (.CLOCK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr_r), .BRESP_O(brsp), .BVALID_O(bv),
    .BREADY_I(br), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rrsp), .RVALID_O(rv),
    .RREADY_I(rr), .OPEN_STATUS_I(ost), .CLOSE_STATUS_I(cst), .CART_IN_INPUT_I(cin), .CART_OUT_INPUT_I(cout),
    .READY_I(rdy), .SYNC_OK_I(syn), .LOCAL_OPEN_I(rq[0]), .LOCAL_CLOSE_I(rq[1]), .REMOTE_OPEN_I(rq[2]),
    .REMOTE_CLOSE_I(rq[3]), .APP_OPEN_I(rq[4]), .APP_CLOSE_I(rq[5]), .PANEL_LEVEL_I(lvl), .RECLOSE_PENDING_I(recl),
    .OPEN_CMD_O(ocmd), .CLOSE_CMD_O(ccmd), .FINAL_TRIP_O(ftrip), .CTRL_ERROR_O(err));
  bko_breaker_model u_bko_breaker_model (.clk_i(clk), .rst_n_i(rst_n), .open_cmd_i(ocmd), .close_cmd_i(ccmd),
    .mode_i(mode), .delay_i(dly), .open_st_o(ost), .close_st_o(cst));
  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  assign hv = {ftrip, ccmd, ocmd};
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
    if (rv && rr) begin
      e = q_r.pop_front();
      `CHK({rrsp, rdat & e[65:34]}, e[33:0])
    end
    if (bv && br) begin
      eb = q_b.pop_front();
      `CHK(brsp, eb)
    end
    for (int i = 0; i < 3; i++) begin
      if (hv[i]) len[i]++;
      else if (len[i] > 0) begin
        if (q_p[i].size() < 2) `CHK(len[i], 0)
        else begin
          lo = q_p[i].pop_front();
          hi = q_p[i].pop_front();
          `CHK(len[i] >= lo && len[i] <= hi, 1'b1)
        end
        len[i] = 0;
      end
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    q_b.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr_r));
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [1:0] r, input logic [31:0] d);
    q_r.push_back({m, r, d});
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic req(input logic [5:0] v, input int l, input int h, input int w);
    if (h > 0) begin
      q_p[w].push_back(l);
      q_p[w].push_back(h);
    end
    rq <= v;
    repeat (8) @(posedge clk);
    rq <= 6'h00;
    repeat (12 * T) @(posedge clk);
  endtask
  initial begin
    void'($urandom(32'h199a6128));
    dly = 8'(15 + $urandom % 10);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`BKO_OFF_CTRL, 32'hffffffff, 2'h0, `BKO_CTRL_RST);
    for (int i = 1; i < 6; i++) rd(12'(4 * i), 32'hffffffff, 2'h0, (i == 4) ? 32'(`BKO_TERM_RST) : 32'h0000000a);
    rd(`BKO_OFF_STAT, 32'h0000006f, 2'h0, 32'h00000069);
    rd(12'h020, 32'hffffffff, 2'h2, 32'h0);
    wr(12'h024, 32'h0, 2'h2);
    wr(`BKO_OFF_TRAV, 32'h2, 2'h0);
    wr(`BKO_OFF_CPUL, 32'h5, 2'h0);
    wr(`BKO_OFF_OPUL, 32'h5, 2'h0);
    wr(`BKO_OFF_TERM, 32'h8, 2'h0);
    wr(`BKO_OFF_FTRP, 32'h3, 2'h0);
    req(6'h02, dly, dly + 12, 1);
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h2);
    q_p[2].push_back(2 * T);
    q_p[2].push_back(4 * T);
    req(6'h09, dly, dly + 12, 0);
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h1);
    mode <= 2'h1;
    req(6'h20, 4 * T, 6 * T, 1);
    `CHK(err, 1'b1)
    rd(`BKO_OFF_STAT, 32'h10, 2'h0, 32'h10);
    wr(`BKO_OFF_STAT, 32'h10, 2'h0);
    rd(`BKO_OFF_STAT, 32'h10, 2'h0, 32'h0);
    mode <= 2'h0;
    syn <= 1'b0;
    wr(`BKO_OFF_CTRL, 32'h15, 2'h0);
    req(6'h20, 0, 0, 1);
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h1);
    syn <= 1'b1;
    rdy <= 1'b0;
    wr(`BKO_OFF_CTRL, 32'h11, 2'h0);
    req(6'h20, 0, 0, 1);
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h1);
    rdy <= 1'b1;
    repeat (8) @(posedge clk);
    req(6'h20, dly, dly + 12, 1);
    recl <= 1'b1;
    for (int l = 0; l < 4; l++) begin
      lvl <= 2'(l);
      repeat (4) @(posedge clk);
      wr(`BKO_OFF_REQ, 32'h0, (l < 2) ? 2'h2 : 2'h0);
    end
    q_p[0].push_back(int'(dly));
    q_p[0].push_back(dly + 12);
    wr(`BKO_OFF_REQ, 32'h1, 2'h0);
    repeat (12 * T) @(posedge clk);
    `CHK(ftrip, 1'b0)
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h1);
    recl <= 1'b0;
    mode <= 2'h2;
    repeat (4) @(posedge clk);
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h1);
    repeat (4 * T) @(posedge clk);
    rd(`BKO_OFF_STAT, 32'h3, 2'h0, 32'h3);
    mode <= 2'h3;
    cin <= 1'b0;
    cout <= 1'b1;
    repeat (4 * T) @(posedge clk);
    rd(`BKO_OFF_STAT, 32'hf, 2'h0, 32'h4);
    complete_run();
  end
endmodule
bind bko_object bko_object_asserts u_bko_object_asserts (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .OPEN_STATUS_I(OPEN_STATUS_I),
  .CLOSE_STATUS_I(CLOSE_STATUS_I), .RECLOSE_PENDING_I(RECLOSE_PENDING_I), .OPEN_CMD_O(OPEN_CMD_O),
  .CLOSE_CMD_O(CLOSE_CMD_O), .FINAL_TRIP_O(FINAL_TRIP_O), .CTRL_ERROR_O(CTRL_ERROR_O));
`default_nettype wire
